//--- rxsc_bitpos.v
/*
 * rxsc_bitpos.v: per-bit alignment of received bits; tracks the aligned
 * bit position, tells where a bit lands, and masks bits after a collision.
 * Assumes: bit_valid pulses once per received data bit on aclk.
 */
`timescale 1ns/1ps
`include "rxsc_defs.vh"

module rxsc_bitpos (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // control
  input wire start,
  input wire [2:0] align,
  input wire keep_after,
  // received bit stream
  input wire bit_valid,
  input wire bit_data,
  input wire bit_coll,
  // results
  output reg [9:0] pos_r,
  output reg coll_seen_r,
  output wire out_data
);

  // bit is forced to zero once a collision was seen and keeping is off
  assign out_data = (coll_seen_r & ~keep_after) ? 1'b0 : bit_data; // [R4]

  // position counts from the aligned start; wraps into next byte naturally
  always @(posedge aclk) begin
    if (!aresetn) begin
      pos_r <= 10'h000;
      coll_seen_r <= 1'b0;
    end else if (start) begin
      pos_r <= {7'h00, align}; // [R5] [R14]
      coll_seen_r <= 1'b0;
    end else if (bit_valid) begin
      pos_r <= pos_r + 10'h001; // [R5]
      if (bit_coll)
        coll_seen_r <= 1'b1;
    end
  end

endmodule

//--- rxsc_card.sv
/* rxsc_card: card side seen through the decoder, one frame per go.
   assumes: go is a one-cycle pulse; gap is at least 1. */
`timescale 1ns/1ps
module rxsc_card (
  // clock
  input wire aclk,
  // frame request
  input wire go,
  input wire [6:0] nbits,
  input wire [7:0] cidx,
  input wire ceof,
  input wire [71:0] data,
  input wire [1:0] gap,
  // decoder events
  output logic rx_start,
  output logic rx_end,
  output logic rx_bit_valid,
  output logic rx_bit_data,
  output logic rx_bit_coll,
  output logic rx_in_eof,
  output logic busy
);
  // frame: start, data bits, optional end-of-frame bit, end
  initial begin
    {rx_start, rx_end, rx_bit_valid, rx_bit_coll, rx_in_eof, busy} = 0;
    rx_bit_data = 0;
    forever begin
      @(posedge aclk);
      if (go) begin
        busy <= 1;
        rx_start <= 1;
        @(posedge aclk);
        rx_start <= 0;
        for (int i = 0; i < nbits + ceof; i++) begin
          repeat (gap) @(posedge aclk);
          rx_bit_valid <= 1;
          rx_bit_data <= data[i];
          rx_bit_coll <= (i == cidx) || (i == nbits);
          rx_in_eof <= (i == nbits);
          @(posedge aclk);
          {rx_bit_valid, rx_bit_coll, rx_in_eof} <= 0;
          rx_bit_data <= ~data[i]; // idle line shows the inverse
        end
        rx_end <= 1;
        @(posedge aclk);
        rx_end <= 0;
        busy <= 0;
      end
    end
  end
endmodule

//--- rxsc_defs.vh
/*
 * rxsc_defs.vh: register offsets, field positions, reset values and
 * state codes for the receive status and collision register block.
 * Assumes: included by bare name from the design files only.
 */
`ifndef RXSC_DEFS_VH
`define RXSC_DEFS_VH

// register indices (byte address is the index x4)
`define RXSC_IDX_STATUS 8'h0B
`define RXSC_IDX_BITCTL 8'h0C
`define RXSC_IDX_COLL 8'h0D
`define RXSC_IDX_IRQ_STAT 8'h20
`define RXSC_IDX_IRQ_MASK 8'h21
`define RXSC_IDX_ERR 8'h22

// transceiver status fields
`define RXSC_ST_CIPHER 5
`define RXSC_ST_STATE_HI 2

// receive bit control fields
`define RXSC_BC_KEEP 7
`define RXSC_BC_ALIGN_HI 6
`define RXSC_BC_ALIGN_LO 4
`define RXSC_BC_COLLISION_AS_INTEGRITY_ERROR 3
`define RXSC_BC_LAST_HI 2

// collision info fields
`define RXSC_CI_VALID 7

// error flag bits
`define RXSC_ERR_INTEG 0
`define RXSC_ERR_COLL 1

// interrupt status bits
`define RXSC_IRQ_COLL 0
`define RXSC_IRQ_RXEND 1
`define RXSC_IRQ_CIPHER 2
`define RXSC_IRQ_W 3

// reset values
`define RXSC_BITCTL_RST 8'h80
`define RXSC_COLL_RST 8'h00

// link state codes
`define RXSC_LS_IDLE 3'h0
`define RXSC_LS_TRANSMIT_WAIT_STATE 3'h1
`define RXSC_LS_TX 3'h3
`define RXSC_LS_RECEIVE_WAIT_STATE 3'h5
`define RXSC_LS_WAITDATA 3'h6
`define RXSC_LS_RX 3'h7

// collision window: first 8 bytes, 64 bit positions
`define RXSC_COLL_LIMIT 7'h40

`endif

//--- rxsc_regs.v
/*
 * rxsc_regs.v: receive status and collision register bank with an
 * AXI4-Lite slave, error flags and a masked level interrupt.
 * Assumes: the receive decoder gives one-cycle pulses from logic on aclk;
 * link_state comes from the transceiver state machine on the same clock.
 * Bus timing: each ready pulses for one cycle while its channel is idle;
 * bvalid follows the second capture by one edge and rvalid rises on the
 * address handshake edge itself. Unmapped addresses answer SLVERR.
 * Hazards: reads see link_state one cycle late, because the state is
 * registered before it reaches the read mux. A write of the status word
 * can only clear the cipher bit; setting it needs the authentication
 * command, which wins over a clear in the same cycle.
 * Limitation: positions beyond the first 8 bytes are reported invalid;
 * the position counter is wide enough for any frame of this block.
 */
// The AXI4-Lite interface to the registers was left to the implementer.
// Operation
// R1: report 3-bit transceiver state, code 100 unused
// R2: bit 5 shows cipher; clearing turns off
// R3: cipher set only by authentication command
// R4: keep bit clear zeroes bits after collision
// R5: first bit stored at aligned position
// R6: align zero means byte-oriented reception
// R7: no-collision bit makes collision set integrity error
// R8: last byte valid bits, zero means whole
// R9: decoder writes count at end, clears at start
// R10: position valid only when position in range
// R11: first collision zero-based data bit position
// R12: positions reported only within first 8 bytes
// R13: host reads position only when valid
// R14: alignment offset added to collision position
// R15: collision sets flag, cleared at receive start
// R16: collision within end-of-frame sets no flag
// R17: reserved bits read zero, writes ignored
`timescale 1ns/1ps
`include "rxsc_defs.vh"

module rxsc_regs (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // transceiver state machine
  input wire [2:0] link_state,
  input wire card_auth_command,
  // receive decoder events
  input wire rx_start,
  input wire rx_end,
  input wire rx_bit_valid,
  input wire rx_bit_data,
  input wire rx_bit_coll,
  input wire rx_in_eof,
  input wire rx_integrity_error,
  // outputs to the datapath
  output reg rx_out_valid,
  output reg rx_out_data,
  output reg card_cipher_active,
  output reg bit_oriented,
  output reg integrity_error,
  output reg collision_detected,
  output reg irq
);

  // register state
  reg [2:0] link_state_r;
  reg cipher_r;
  reg keep_r;
  reg [2:0] align_r;
  reg collision_as_integrity_error_r;
  reg [2:0] last_bits_r;
  reg coll_valid_r;
  reg [6:0] coll_pos_r;
  reg integ_r;
  reg collision_detected_r;
  reg [`RXSC_IRQ_W-1:0] irq_stat_r;
  reg [`RXSC_IRQ_W-1:0] irq_mask_r;

  // axi holding registers
  // address and data are held separately until both have arrived
  reg aw_have_r;
  reg w_have_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;

  // from the alignment helper
  wire [9:0] pos;
  wire coll_seen;
  wire masked_bit;

  rxsc_bitpos u_bitpos (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(rx_start),
    .align(align_r),
    .keep_after(keep_r),
    .bit_valid(rx_bit_valid),
    .bit_data(rx_bit_data),
    .bit_coll(rx_bit_coll),
    .pos_r(pos),
    .coll_seen_r(coll_seen),
    .out_data(masked_bit)
  );

  // a collision counts only if it is not in the eof; first_coll marks the first counted one
  // the eof test keeps a collision inside the end-of-frame symbol from
  // raising any flag, position or interrupt
  wire coll_evt = rx_bit_valid & rx_bit_coll & ~rx_in_eof; // [R16]
  wire first_coll = coll_evt & ~coll_seen;
  wire coll_in_range = (pos < {3'h0, `RXSC_COLL_LIMIT}); // [R12]

  // write decode
  // only byte lane 0 carries register bits; other lanes are ignored,
  // and a write with lane 0 off to a mapped address still gets an OKAY response
  wire do_write = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire wr_lane0 = do_write & w_strb_r[0];
  wire wr_stat = wr_lane0 & (aw_addr_r == {`RXSC_IDX_STATUS, 2'b00});
  wire wr_bctl = wr_lane0 & (aw_addr_r == {`RXSC_IDX_BITCTL, 2'b00});
  wire wr_istat = wr_lane0 & (aw_addr_r == {`RXSC_IDX_IRQ_STAT, 2'b00});
  wire wr_imask = wr_lane0 & (aw_addr_r == {`RXSC_IDX_IRQ_MASK, 2'b00});
  wire wr_known = (aw_addr_r == {`RXSC_IDX_STATUS, 2'b00}) |
                  (aw_addr_r == {`RXSC_IDX_BITCTL, 2'b00}) |
                  (aw_addr_r == {`RXSC_IDX_COLL, 2'b00}) |
                  (aw_addr_r == {`RXSC_IDX_IRQ_STAT, 2'b00}) |
                  (aw_addr_r == {`RXSC_IDX_IRQ_MASK, 2'b00}) |
                  (aw_addr_r == {`RXSC_IDX_ERR, 2'b00});

  // status events for the interrupt register
  // each event is a single-cycle pulse; the collision event fires only
  // for the first collision of a frame, the cipher event only on a set
  wire [`RXSC_IRQ_W-1:0] irq_evt;
  assign irq_evt[`RXSC_IRQ_COLL] = coll_evt & ~collision_detected_r;
  assign irq_evt[`RXSC_IRQ_RXEND] = rx_end;
  assign irq_evt[`RXSC_IRQ_CIPHER] = card_auth_command & ~cipher_r;

  // axi write channel capture and response
  // each channel is captured in its own holding register, so address and
  // data may arrive in either order; the response waits for both and no
  // new capture starts until bready has taken the response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= ~aw_have_r & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= ~w_have_r & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // reset image of the bit control register, taken apart by field
  wire [7:0] bitctl_rst = `RXSC_BITCTL_RST;

  // software-controlled registers and the cipher bit
  // the cipher bit is shared between software and the command engine,
  // so the command has priority to keep a fresh authentication alive
  always @(posedge aclk) begin
    if (!aresetn) begin
      cipher_r <= 1'b0;
      keep_r <= bitctl_rst[`RXSC_BC_KEEP];
      align_r <= 3'h0;
      collision_as_integrity_error_r <= 1'b0;
      irq_mask_r <= {`RXSC_IRQ_W{1'b0}};
    end else begin
      // only the authentication command sets; a written zero clears
      if (card_auth_command)
        cipher_r <= 1'b1; // [R3]
      else if (wr_stat & ~w_data_r[`RXSC_ST_CIPHER])
        cipher_r <= 1'b0; // [R2]
      // reserved bits of the write are dropped
      if (wr_bctl) begin
        keep_r <= w_data_r[`RXSC_BC_KEEP];
        align_r <= w_data_r[`RXSC_BC_ALIGN_HI:`RXSC_BC_ALIGN_LO];
        collision_as_integrity_error_r <= w_data_r[`RXSC_BC_COLLISION_AS_INTEGRITY_ERROR]; // [R17]
      end
      if (wr_imask)
        irq_mask_r <= w_data_r[`RXSC_IRQ_W-1:0];
    end
  end

  // decoder-updated fields: last bits, collision info and error flags
  // start of reception wins over every event in the same cycle, so a
  // stale collision of the previous frame never leaks into the new one;
  // only the first counted collision loads the position
  always @(posedge aclk) begin
    if (!aresetn) begin
      last_bits_r <= 3'h0;
      coll_valid_r <= 1'b0;
      coll_pos_r <= 7'h00;
      integ_r <= 1'b0;
      collision_detected_r <= 1'b0;
    end else if (rx_start) begin
      last_bits_r <= 3'h0; // [R9]
      coll_valid_r <= 1'b0;
      coll_pos_r <= 7'h00;
      integ_r <= 1'b0; // [R15]
      collision_detected_r <= 1'b0; // [R15]
    end else begin
      // count of valid bits in the last byte, only in bit mode
      if (rx_end & (align_r != 3'h0))
        last_bits_r <= pos[2:0]; // [R8] [R9]
      if (coll_evt)
        collision_detected_r <= 1'b1; // [R15]
      if (rx_integrity_error | (coll_evt & collision_as_integrity_error_r))
        integ_r <= 1'b1; // [R7]
      // first collision position, aligned, within first 8 bytes
      if (first_coll & ~rx_in_eof) begin
        coll_pos_r <= coll_in_range ? pos[6:0] : 7'h00; // [R11] [R14]
        coll_valid_r <= coll_in_range; // [R10] [R12]
      end
    end
  end

  // sticky interrupt status, write one to clear, set wins
  // so no event is lost when software clears status while the decoder
  // raises the same bit
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= {`RXSC_IRQ_W{1'b0}};
    end else begin
      irq_stat_r <= (irq_stat_r &
        ~(wr_istat ? w_data_r[`RXSC_IRQ_W-1:0] : {`RXSC_IRQ_W{1'b0}}))
        | irq_evt;
    end
  end

  // registered outputs
  // every top-level output is a flip-flop; the levels lag the register
  // state by one cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      link_state_r <= `RXSC_LS_IDLE;
      rx_out_valid <= 1'b0;
      rx_out_data <= 1'b0;
      card_cipher_active <= 1'b0;
      bit_oriented <= 1'b0;
      integrity_error <= 1'b0;
      collision_detected <= 1'b0;
      irq <= 1'b0;
    end else begin
      link_state_r <= link_state; // [R1]
      rx_out_valid <= rx_bit_valid;
      rx_out_data <= masked_bit; // [R4]
      card_cipher_active <= cipher_r;
      bit_oriented <= (align_r != 3'h0); // [R6]
      integrity_error <= integ_r;
      collision_detected <= collision_detected_r;
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // read data mux, reserved bits zero
  // the mux follows araddr directly; the master holds the address until
  // the handshake edge, at which the data word is captured
  reg [31:0] rd_mux;
  reg rd_known;
  always @* begin
    rd_mux = 32'h00000000;
    rd_known = 1'b1;
    case (s_axi_araddr)
      {`RXSC_IDX_STATUS, 2'b00}:
        rd_mux[7:0] = {2'b00, cipher_r, 2'b00, link_state_r}; // [R1] [R17]
      {`RXSC_IDX_BITCTL, 2'b00}:
        rd_mux[7:0] = {keep_r, align_r, collision_as_integrity_error_r, last_bits_r};
      {`RXSC_IDX_COLL, 2'b00}:
        rd_mux[7:0] = {coll_valid_r, coll_pos_r}; // [R10]
      {`RXSC_IDX_IRQ_STAT, 2'b00}:
        rd_mux[`RXSC_IRQ_W-1:0] = irq_stat_r;
      {`RXSC_IDX_IRQ_MASK, 2'b00}:
        rd_mux[`RXSC_IRQ_W-1:0] = irq_mask_r;
      {`RXSC_IDX_ERR, 2'b00}:
        rd_mux[1:0] = {collision_detected_r, integ_r};
      default:
        rd_known = 1'b0;
    endcase
  end

  // axi read channel: address taken, data one cycle later
  // arready stays low while a read answer is pending, so only one read
  // is ever under way
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & ~s_axi_arvalid
                       | (~s_axi_rvalid & ~s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_known ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

//--- rxsc_regs_chk.sv
/* rxsc_regs_chk: port assertions for the receive register block.
   assumes: bound to rxsc_regs, single clock, sync active-low reset. */
`timescale 1ns/1ps
module rxsc_chk (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // bus read data
  input wire s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  // decoder and state machine
  input wire card_auth_command,
  input wire rx_start,
  input wire rx_bit_valid,
  input wire rx_bit_coll,
  input wire rx_in_eof,
  input wire rx_integrity_error,
  // outputs watched
  input wire rx_out_valid,
  input wire card_cipher_active,
  input wire integrity_error,
  input wire collision_detected
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a collision on a counted data bit
  wire coll_now = rx_bit_valid && rx_bit_coll && !rx_in_eof;
  wire integ_now = coll_now || rx_integrity_error;
  sequence coll_bit;
    coll_now ##1 !rx_start;
  endsequence
  sequence start_quiet;
    rx_start ##1 !rx_bit_valid;
  endsequence
  a_coll_flag_set: assert property (
    coll_bit |-> ##[0:2] collision_detected) else $error("flag missed");
  a_coll_flag_cause: assert property (
    $rose(collision_detected) |-> $past(coll_now) || $past(coll_now, 2)
    || $past(coll_now, 3)) else $error("flag without cause");
  a_coll_flag_clr: assert property (
    start_quiet |-> ##[0:2] !collision_detected) else $error("flag kept");
  a_cipher_by_auth: assert property (
    $rose(card_cipher_active) |-> $past(card_auth_command)
    || $past(card_auth_command, 2)) else $error("cipher set wrongly");
  a_cipher_on_auth: assert property (
    card_auth_command |-> ##[1:3] card_cipher_active) else $error("no cipher");
  a_integ_cause: assert property (
    $rose(integrity_error) |-> $past(integ_now) || $past(integ_now, 2)
    || $past(integ_now, 3)) else $error("integrity without cause");
  a_out_follow: assert property (
    rx_bit_valid |=> rx_out_valid) else $error("bit not passed on");
  a_rdata_resv: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
endmodule
bind rxsc_regs rxsc_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .card_auth_command(card_auth_command), .rx_start(rx_start),
  .rx_bit_valid(rx_bit_valid), .rx_bit_coll(rx_bit_coll),
  .rx_in_eof(rx_in_eof), .rx_integrity_error(rx_integrity_error),
  .rx_out_valid(rx_out_valid), .card_cipher_active(card_cipher_active),
  .integrity_error(integrity_error),
  .collision_detected(collision_detected));

//--- tb_rx_status_collision_regs.sv
/* tb_rx_status_collision_regs: bus tests and random frames against a model.
   assumes: rxsc_regs with byte addresses of index times four. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fails++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end
module tb_rx_status_collision_regs;
  logic aclk = 0, aresetn = 0, go = 0, ce, kp, auth = 0;
  logic [7:0] aw_a = 0, ar_a = 0, d, ci = 8'hFF, lb, pos;
  logic [31:0] wd = 0;
  logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [2:0] ls = 0, al;
  logic [6:0] nb = 8;
  logic [1:0] gap = 1, wres, r;
  logic [71:0] dat = 0;
  wire awr, wr_rdy, bv, arr, rv, sv, sc, se, sd, sb, sx, so, od, ca, bo;
  wire ie, cd, irq, busy;
  wire [1:0] br_s, rr_s;
  wire [31:0] rd_s;
  int fails = 0, compares = 0, k = 0;
  int codes[6] = '{0, 1, 3, 5, 6, 7};
  // clock
  always #20 aclk = ~aclk;
  rxsc_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(br_s), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ar_a), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd_s), .s_axi_rresp(rr_s), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .link_state(ls), .card_auth_command(auth),
    .rx_start(sv), .rx_end(se), .rx_bit_valid(sb), .rx_bit_data(sd),
    .rx_bit_coll(sc), .rx_in_eof(sx), .rx_integrity_error(1'b0),
    .rx_out_valid(so), .rx_out_data(od), .card_cipher_active(ca),
    .bit_oriented(bo), .integrity_error(ie), .collision_detected(cd),
    .irq(irq));
  rxsc_card u_card (.aclk(aclk), .go(go), .nbits(nb), .cidx(ci),
    .ceof(ce), .data(dat), .gap(gap), .rx_start(sv), .rx_end(se),
    .rx_bit_valid(sb), .rx_bit_data(sd), .rx_bit_coll(sc), .rx_in_eof(sx),
    .busy(busy));
  // bus write, both channels offered together
  task automatic wr(input [7:0] a, input [7:0] v);
    int n = 0;
    bit ad = 0, dd = 0;
    aw_a <= a; wd <= {24'h0, v}; awv <= 1; wv <= 1; br <= 1;
    while (n < 100) begin
      @(posedge aclk); n++;
      if (ad && dd && bv) break;
      if (!ad && awr) begin ad = 1; awv <= 0; end
      if (!dd && wr_rdy) begin dd = 1; wv <= 0; end
    end
    wres = br_s; br <= 0;
    if (n >= 100) fails++;
  endtask
  // bus read
  task automatic rd(input [7:0] a);
    int n = 0;
    ar_a <= a; arv <= 1; rr <= 1;
    while (n < 100) begin
      @(posedge aclk); n++;
      if (arv && arr) arv <= 0;
      else if (!arv && rv) break;
    end
    d = rd_s[7:0]; r = rr_s; rr <= 0;
    if (n >= 100) fails++;
  endtask
  task results;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // received bit stream, zeroed after a collision when not kept
  always @(posedge aclk) if (so) begin
    if (k != ci) `CHK("out bit", (!kp && k > ci) ? 1'b0 : dat[k], od)
    k++;
  end
  // watchdog
  initial begin #2000000; fails++; results(); end
  initial begin
    void'($urandom(32'h0BF8));
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(8'h30); `CHK("ctl reset", 8'h80, d)
    rd(8'h34); `CHK("coll reset", 8'h00, d)
    rd(8'h40); `CHK("bad rd", 2'h2, r)
    wr(8'h40, 8'hFF); `CHK("bad wr", 2'h2, wres)
    wr(8'h2C, 8'hFF);
    foreach (codes[i]) begin
      ls <= codes[i]; @(posedge aclk); rd(8'h2C);
      `CHK("status", {5'h0, codes[i][2:0]}, d)
    end
    $display("status test done");
    auth <= 1; @(posedge aclk); auth <= 0; repeat (3) @(posedge aclk);
    rd(8'h2C); `CHK("cipher on", 8'h27, d)
    rd(8'h80); `CHK("irq cipher", 8'h04, d)
    wr(8'h84, 8'h04); @(posedge aclk); `CHK("irq open", 1'b1, irq)
    wr(8'h84, 8'h00); @(posedge aclk); `CHK("irq masked", 1'b0, irq)
    wr(8'h2C, 8'h00); rd(8'h2C); `CHK("cipher off", 8'h07, d)
    wr(8'h80, 8'h07); wr(8'h84, 8'h07); rd(8'h80); `CHK("irq clr", 8'h0, d)
    $display("cipher test done");
    for (int f = 0; f < 12; f++) begin
      al = $urandom; kp = $urandom; nb = 8 + $urandom % 63;
      ce = (f % 4 == 1); ci = (f % 3 == 0 || ce) ? 8'hFF : $urandom % nb;
      if (f == 2 || f == 6) begin nb = 71; ci = 63 - al + (f == 6); end
      dat = {$urandom, $urandom, $urandom} & ((72'h1 << nb) - 1);
      wr(8'h30, {kp, al, f[0], 3'h0});
      gap <= 1 + $urandom % 3; go <= 1;
      @(posedge aclk); go <= 0; k = 0; repeat (3) @(posedge aclk);
      rd(8'h30); `CHK("ctl mid", {kp, al, f[0], 3'h0}, d)
      while (busy) @(posedge aclk);
      repeat (3) @(posedge aclk);
      pos = al + ci;
      rd(8'h34);
      `CHK("coll", (ci != 8'hFF && pos < 64) ? {1'b1, pos[6:0]} : 8'h0, d)
      lb = (al != 0) ? (al + nb) % 8 : 0;
      rd(8'h30); if (!ce) `CHK("last bits", lb[2:0], d[2:0])
      `CHK("coll flag", ci != 8'hFF, cd)
      `CHK("integ", f[0] && ci != 8'hFF, ie)
      `CHK("bit mode", al != 0, bo)
    end
    rd(8'h80); `CHK("irq frames", 8'h03, d)
    `CHK("irq level", 1'b1, irq)
    wr(8'h80, 8'h03); @(posedge aclk); `CHK("irq clear", 1'b0, irq)
    $display("frame test done");
    results();
  end
endmodule
